// ==== core/cascade_timer_pkg.sv ====
/*
 * constants, mode and source codes and the state record types shared by the
 * cascadable timer/counter top and its counting unit.
 * assumes one 40 MHz clock that also serves as the high-frequency source clock.
 */
package cascade_timer_pkg;

	localparam int CNT_W = 8;
	localparam int PRESC_W = 11;
	localparam int FS_DIV_W = 3;
	localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
	localparam logic [PRESC_W-1:0] PRESC_RST = 11'h000;
	localparam logic [FS_DIV_W-1:0] FS_DIV_LAST = 3'h7;

	// mode codes
	localparam logic [2:0] MODE_TIMER = 3'h0;
	localparam logic [2:0] MODE_DIVIDER = 3'h1;
	localparam logic [2:0] MODE_PWM8 = 3'h2;
	localparam logic [2:0] MODE_CASCADE_LOW = 3'h3;
	localparam logic [2:0] MODE_TIMER16 = 3'h4;
	localparam logic [2:0] MODE_WARMUP = 3'h5;
	localparam logic [2:0] MODE_PWM16 = 3'h6;
	localparam logic [2:0] MODE_PULSE_GEN = 3'h7;

	// source clock codes
	localparam logic [2:0] SRC_SLOWEST = 3'h0;
	localparam logic [2:0] SRC_FC_DIV7 = 3'h1;
	localparam logic [2:0] SRC_FC_DIV5 = 3'h2;
	localparam logic [2:0] SRC_FC_DIV3 = 3'h3;
	localparam logic [2:0] SRC_FS = 3'h4;
	localparam logic [2:0] SRC_FC_DIV1 = 3'h5;
	localparam logic [2:0] SRC_FC = 3'h6;
	localparam logic [2:0] SRC_PIN = 3'h7;

	typedef struct packed {
		logic [CNT_W-1:0] count;
	} unit_state_t;

	typedef struct packed {
		logic [PRESC_W-1:0] presc;
		logic [2:0] fs_sync;
		logic fs_lvl;
		logic [FS_DIV_W-1:0] fs_div;
		logic [2:0] ev_sync;
		logic ev_lvl;
		logic irq_lo;
		logic irq_hi;
		logic cfg_err;
	} top_state_t;

endpackage

// ==== core/timer_unit_if.sv ====
/*
 * signals between the timer top and one 8-bit counting unit.
 * assumes the top drives tick, clear, compare and compare enable each cycle.
 */
`timescale 1ns/1ps
interface timer_unit_if;
	logic tick;
	logic clr;
	logic cmp_en;
	logic [7:0] cmp;
	logic [7:0] count;
	logic match;
	logic wrap;

	modport core (input tick, input clr, input cmp_en, input cmp,
		output count, output match, output wrap);
	modport ctrl (output tick, output clr, output cmp_en, output cmp,
		input count, input match, input wrap);
endinterface

// ==== core/timer_unit_core.sv ====
/*
 * one 8-bit up-counter with live compare, match pulse and overflow pulse.
 * assumes tick is a one-cycle pulse on the same clock and clr overrides it.
 */
`timescale 1ns/1ps
module timer_unit_core (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// control and status
	timer_unit_if.core bus
);
	cascade_timer_pkg::unit_state_t st_ff, nxt_st;
	logic [7:0] inc;

	assign inc = st_ff.count + 8'h01;
	assign bus.count = st_ff.count;
	// compare uses the present register value, no shadow copy
	assign bus.match = bus.tick && !bus.clr && bus.cmp_en && (inc == bus.cmp);
	assign bus.wrap = bus.tick && !bus.clr && !bus.match && (inc == 8'h00);

	always_comb begin
		nxt_st = st_ff;
		if (bus.clr) begin
			nxt_st.count = cascade_timer_pkg::CNT_RST;
		end else if (bus.match) begin
			nxt_st.count = cascade_timer_pkg::CNT_RST;
		end else if (bus.tick) begin
			nxt_st.count = inc;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	count_steps_a: assert property (bus.tick && !bus.clr && !bus.match |=>
		st_ff.count == $past(inc))
		else $error("count did not step on tick");
	clear_holds_a: assert property (bus.clr [*2] |-> st_ff.count == 8'h00 && !bus.match)
		else $error("cleared unit left zero or matched");
endmodule

// ==== core/cascade_timer_top.sv ====
/*
 * two 8-bit timer/counters with per-mode source checking, prescaler, event pin
 * and 16-bit cascade. settings arrive as plain ports.
 * assumes CLK is the high-frequency clock; the low-frequency clock and the
 * event pin are asynchronous inputs sampled here.
 */
`timescale 1ns/1ps
module cascade_timer_top (
	// clock and reset
	input wire logic CLK,
	input wire logic ARST_N,
	// asynchronous inputs
	input wire logic LOW_FREQ_CLK,
	input wire logic EVENT_PIN,
	// system settings
	input wire logic LOW_SPEED_MODE,
	input wire logic DIVIDER_TAP_SELECT,
	// lower unit settings
	input wire logic LOWER_RUN,
	input wire logic [2:0] LOWER_MODE_SELECT,
	input wire logic [2:0] LOWER_UNIT_CLOCK_SELECT,
	input wire logic [7:0] TIMER_COMPARE_REG_LO,
	// upper unit settings
	input wire logic UPPER_RUN,
	input wire logic [2:0] UPPER_MODE_SELECT,
	input wire logic [2:0] UPPER_CLOCK_SELECT,
	input wire logic [7:0] TIMER_COMPARE_REG_HI,
	// status
	output logic MATCH_INTERRUPT_LO,
	output logic MATCH_INTERRUPT_HI,
	output logic [7:0] COUNT_LO,
	output logic [7:0] COUNT_HI,
	output logic SOURCE_SELECT_ERROR
);
	cascade_timer_pkg::top_state_t st_ff, nxt_st;
	timer_unit_if unit[2] ();

	logic cascade;
	logic fc11, fc7, fc5, fc3, fc1;
	logic fs_edge, fs8_tick, ev_fall, slow_tick;
	logic [2:0] lo_mode;
	logic lo_ok, hi_ok, lo_run, m16;
	logic [15:0] cnt16_inc;

	// legal source per mode and system speed
	function automatic logic src_allowed(input logic [2:0] mode, input logic [2:0] sel,
		input logic low, input logic pin_ok);
		logic ok;
		ok = 1'b0;
		case (mode)
			cascade_timer_pkg::MODE_TIMER, cascade_timer_pkg::MODE_TIMER16: begin
				ok = (low ? sel == cascade_timer_pkg::SRC_SLOWEST
					: sel <= cascade_timer_pkg::SRC_FC_DIV3)
					|| (pin_ok && sel == cascade_timer_pkg::SRC_PIN);
			end
			cascade_timer_pkg::MODE_DIVIDER, cascade_timer_pkg::MODE_PULSE_GEN: begin
				ok = low ? sel == cascade_timer_pkg::SRC_SLOWEST
					: sel <= cascade_timer_pkg::SRC_FC_DIV3;
			end
			cascade_timer_pkg::MODE_PWM8, cascade_timer_pkg::MODE_PWM16: begin
				ok = low ? (sel == cascade_timer_pkg::SRC_SLOWEST
					|| sel == cascade_timer_pkg::SRC_FS)
					: sel != cascade_timer_pkg::SRC_PIN;
			end
			cascade_timer_pkg::MODE_WARMUP: begin
				ok = low ? sel == cascade_timer_pkg::SRC_FC
					: sel == cascade_timer_pkg::SRC_FS;
			end
			default: begin
				ok = 1'b0;
			end
		endcase
		return ok;
	endfunction

	function automatic logic src_tick(input logic [2:0] sel, input logic slow,
		input logic f7, input logic f5, input logic f3, input logic f1,
		input logic fs, input logic ev);
		logic t;
		t = 1'b0;
		case (sel)
			cascade_timer_pkg::SRC_SLOWEST: t = slow;
			cascade_timer_pkg::SRC_FC_DIV7: t = f7;
			cascade_timer_pkg::SRC_FC_DIV5: t = f5;
			cascade_timer_pkg::SRC_FC_DIV3: t = f3;
			cascade_timer_pkg::SRC_FS: t = fs;
			cascade_timer_pkg::SRC_FC_DIV1: t = f1;
			cascade_timer_pkg::SRC_FC: t = 1'b1;
			default: t = ev;
		endcase
		return t;
	endfunction

	// upper mode 1xx makes the pair one 16-bit counter
	assign cascade = UPPER_MODE_SELECT[2];
	assign fc11 = &st_ff.presc[10:0];
	assign fc7 = &st_ff.presc[6:0];
	assign fc5 = &st_ff.presc[4:0];
	assign fc3 = &st_ff.presc[2:0];
	assign fc1 = st_ff.presc[0];
	assign fs_edge = (st_ff.fs_sync[1] == st_ff.fs_sync[2]) && st_ff.fs_sync[2]
		&& !st_ff.fs_lvl;
	assign fs8_tick = fs_edge && (st_ff.fs_div == cascade_timer_pkg::FS_DIV_LAST);
	assign ev_fall = (st_ff.ev_sync[1] == st_ff.ev_sync[2]) && !st_ff.ev_sync[2]
		&& st_ff.ev_lvl;
	assign slow_tick = (LOW_SPEED_MODE || DIVIDER_TAP_SELECT) ? fs8_tick : fc11;

	// in 16-bit modes the lower unit is checked against the shared mode
	assign lo_mode = cascade ? UPPER_MODE_SELECT : LOWER_MODE_SELECT;
	assign lo_ok = src_allowed(lo_mode, LOWER_UNIT_CLOCK_SELECT, LOW_SPEED_MODE, cascade)
		&& (!cascade || LOWER_MODE_SELECT == cascade_timer_pkg::MODE_CASCADE_LOW);
	assign hi_ok = src_allowed(UPPER_MODE_SELECT, UPPER_CLOCK_SELECT, LOW_SPEED_MODE, 1'b1);
	assign lo_run = cascade ? UPPER_RUN : LOWER_RUN;
	assign cnt16_inc = {unit[1].count, unit[0].count} + 16'h0001;
	assign m16 = cascade && unit[0].tick
		&& cnt16_inc == {TIMER_COMPARE_REG_HI, TIMER_COMPARE_REG_LO};

	assign unit[0].tick = lo_run && lo_ok && src_tick(LOWER_UNIT_CLOCK_SELECT, slow_tick,
		fc7, fc5, fc3, fc1, fs_edge, ev_fall);
	assign unit[0].clr = !lo_run || m16;
	assign unit[0].cmp_en = !cascade;
	assign unit[0].cmp = TIMER_COMPARE_REG_LO;
	// cascaded upper byte ignores its own clock select
	assign unit[1].tick = cascade ? unit[0].wrap
		: UPPER_RUN && hi_ok && src_tick(UPPER_CLOCK_SELECT, slow_tick,
		fc7, fc5, fc3, fc1, fs_edge, ev_fall);
	assign unit[1].clr = !UPPER_RUN || m16;
	assign unit[1].cmp_en = !cascade;
	assign unit[1].cmp = TIMER_COMPARE_REG_HI;

	for (genvar i = 0; i < 2; i++) begin : g_unit
		timer_unit_core u_core (
			.clk(CLK),
			.arst_n(ARST_N),
			.bus(unit[i])
		);
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_st.presc = st_ff.presc + 11'h001;
		nxt_st.fs_sync = {st_ff.fs_sync[1:0], LOW_FREQ_CLK};
		nxt_st.ev_sync = {st_ff.ev_sync[1:0], EVENT_PIN};
		if (st_ff.fs_sync[1] == st_ff.fs_sync[2]) begin
			nxt_st.fs_lvl = st_ff.fs_sync[2];
		end
		if (st_ff.ev_sync[1] == st_ff.ev_sync[2]) begin
			nxt_st.ev_lvl = st_ff.ev_sync[2];
		end
		if (fs_edge) begin
			nxt_st.fs_div = st_ff.fs_div + 3'h1;
		end
		nxt_st.irq_lo = unit[0].match;
		nxt_st.irq_hi = unit[1].match || m16;
		nxt_st.cfg_err = (lo_run && !lo_ok) || (!cascade && UPPER_RUN && !hi_ok);
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign MATCH_INTERRUPT_LO = st_ff.irq_lo;
	assign MATCH_INTERRUPT_HI = st_ff.irq_hi;
	assign COUNT_LO = unit[0].count;
	assign COUNT_HI = unit[1].count;
	assign SOURCE_SELECT_ERROR = st_ff.cfg_err;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);

	sequence slow_fast_s;
		fc11 && !LOW_SPEED_MODE && !DIVIDER_TAP_SELECT;
	endsequence
	sequence quiet_gap_s;
		!fc11 [*8];
	endsequence

	match_clears_lo_a: assert property (unit[0].match |=> COUNT_LO == 8'h00
		&& MATCH_INTERRUPT_LO)
		else $error("lower match did not clear or interrupt");
	live_compare_a: assert property (unit[0].tick && LOWER_RUN && !cascade
		&& COUNT_LO + 8'h01 == TIMER_COMPARE_REG_LO |-> unit[0].match)
		else $error("compare missed the present register value");
	cascade_clock_a: assert property (cascade && unit[1].tick |-> unit[0].wrap)
		else $error("cascaded upper byte ticked without overflow");
	cascade_match_a: assert property (m16 |=> COUNT_LO == 8'h00 && COUNT_HI == 8'h00
		&& MATCH_INTERRUPT_HI)
		else $error("16-bit match did not clear the pair");
	stopped_quiet_a: assert property (!UPPER_RUN [*2] |=> COUNT_HI == 8'h00
		&& !MATCH_INTERRUPT_HI)
		else $error("stopped upper unit moved or interrupted");
	full_speed_src_a: assert property (!LOW_SPEED_MODE && !cascade
		&& LOWER_MODE_SELECT == cascade_timer_pkg::MODE_TIMER
		&& LOWER_UNIT_CLOCK_SELECT == cascade_timer_pkg::SRC_FC |-> !unit[0].tick)
		else $error("timer mode ticked on an illegal source");
	low_speed_src_a: assert property (LOW_SPEED_MODE && !cascade && LOWER_RUN
		&& LOWER_MODE_SELECT == cascade_timer_pkg::MODE_TIMER
		&& LOWER_UNIT_CLOCK_SELECT == cascade_timer_pkg::SRC_FC_DIV7 |=> SOURCE_SELECT_ERROR)
		else $error("illegal low-speed source not flagged");
	slow_spacing_a: assert property (slow_fast_s |=> quiet_gap_s)
		else $error("slowest prescaled tick too close");
	src_from_lower_a: assert property (cascade && UPPER_RUN && lo_ok
		&& LOWER_UNIT_CLOCK_SELECT == cascade_timer_pkg::SRC_FC |-> unit[0].tick)
		else $error("16-bit source not taken from lower select");

	// lower-unit stop, refused sources and the event input
	sequence pin_src_s;
		!cascade && UPPER_RUN && hi_ok && UPPER_CLOCK_SELECT == cascade_timer_pkg::SRC_PIN;
	endsequence
	stopped_lower_a: assert property (!lo_run [*2] |=> COUNT_LO == 8'h00
		&& !MATCH_INTERRUPT_LO)
		else $error("stopped lower unit moved or interrupted");
	illegal_idle_a: assert property (lo_run && !lo_ok
		|-> !unit[0].tick ##1 SOURCE_SELECT_ERROR)
		else $error("illegal lower source ticked or went unflagged");
	pin_count_a: assert property (pin_src_s |-> unit[1].tick == ev_fall)
		else $error("event input count did not follow the pin");
	upper_src_a: assert property (!cascade && unit[1].tick |-> UPPER_RUN && hi_ok)
		else $error("upper unit ticked while stopped or on an illegal source");
endmodule

// ==== verif/cascade_timer_top_tb.sv ====
/*
 * self-checking bench for the cascadable timer/counter top: periods, live compare,
 * stopped hold, source legality, cascade, event pin and slowest-source taps.
 * assumes the package, unit interface and unit core are compiled before it.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cascade_timer_top_tb;
	logic CLK = 1'b0, ARST_N = 1'b1, LOW_FREQ_CLK = 1'b0, EVENT_PIN = 1'b1;
	logic LOW_SPEED_MODE = 1'b0, DIVIDER_TAP_SELECT = 1'b0, LOWER_RUN = 1'b0, UPPER_RUN = 1'b0;
	logic [2:0] LOWER_MODE_SELECT = 3'h0, LOWER_UNIT_CLOCK_SELECT = 3'h0;
	logic [2:0] UPPER_MODE_SELECT = 3'h0, UPPER_CLOCK_SELECT = 3'h0;
	logic [7:0] TIMER_COMPARE_REG_LO = 8'h01, TIMER_COMPARE_REG_HI = 8'h01;
	logic MATCH_INTERRUPT_LO, MATCH_INTERRUPT_HI, SOURCE_SELECT_ERROR;
	logic [7:0] COUNT_LO, COUNT_HI;
	int bad_count = 0, checked = 0, n, k;
	logic [7:0] cmps [0:2] = '{8'h01, 8'h03, 8'hff};
	// {speed, lo run, lo mode, lo src, hi run, hi mode, hi src, error expected}
	logic [15:0] rows [0:24] = '{16'h4100, 16'h4601, 16'h4401, 16'h4d01, 16'h5600,
		16'h5400, 16'h4701, 16'h008e, 16'h0089, 16'h1cd0, 16'h1bd1, 16'h1acc, 16'h1ec1,
		16'h1de0, 16'h1ef1, 16'hc000, 16'hc101, 16'hd400, 16'hd601, 16'h9ed0, 16'h9cd1,
		16'h9bc1, 16'h9ce0, 16'h98f0, 16'h808e};

	cascade_timer_top uut (.CLK(CLK), .ARST_N(ARST_N), .LOW_FREQ_CLK(LOW_FREQ_CLK),
		.EVENT_PIN(EVENT_PIN), .LOW_SPEED_MODE(LOW_SPEED_MODE),
		.DIVIDER_TAP_SELECT(DIVIDER_TAP_SELECT), .LOWER_RUN(LOWER_RUN),
		.LOWER_MODE_SELECT(LOWER_MODE_SELECT), .LOWER_UNIT_CLOCK_SELECT(LOWER_UNIT_CLOCK_SELECT),
		.TIMER_COMPARE_REG_LO(TIMER_COMPARE_REG_LO), .UPPER_RUN(UPPER_RUN),
		.UPPER_MODE_SELECT(UPPER_MODE_SELECT), .UPPER_CLOCK_SELECT(UPPER_CLOCK_SELECT),
		.TIMER_COMPARE_REG_HI(TIMER_COMPARE_REG_HI), .MATCH_INTERRUPT_LO(MATCH_INTERRUPT_LO),
		.MATCH_INTERRUPT_HI(MATCH_INTERRUPT_HI), .COUNT_LO(COUNT_LO), .COUNT_HI(COUNT_HI),
		.SOURCE_SELECT_ERROR(SOURCE_SELECT_ERROR));

	always #12.5 CLK = ~CLK;

	task automatic cyc(input int c);
		repeat (c) @(negedge CLK);
	endtask

	task automatic summarize();
		$display("comparisons=%0d mismatches=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic timeout();
		`CHK(1'b0, 1'b1)
		summarize();
	endtask

	// applied only while stopped or together with the start; no output flip-flop init input
	task automatic cfg(input logic [15:0] r);
		{LOW_SPEED_MODE, LOWER_RUN, LOWER_MODE_SELECT, LOWER_UNIT_CLOCK_SELECT,
			UPPER_RUN, UPPER_MODE_SELECT, UPPER_CLOCK_SELECT} = r[15:1];
	endtask

	// settings stay put, only the run bits drop
	task automatic stop();
		LOWER_RUN = 1'b0;
		UPPER_RUN = 1'b0;
		cyc(2);
	endtask

	task automatic wait_irq(input logic hi, input int lim);
		n = 0;
		do begin
			@(negedge CLK);
			n++;
		end while ((hi ? MATCH_INTERRUPT_HI : MATCH_INTERRUPT_LO) !== 1'b1 && n < lim);
		if ((hi ? MATCH_INTERRUPT_HI : MATCH_INTERRUPT_LO) !== 1'b1)
			timeout();
	endtask

	task automatic wait_cnt(input logic hi, input logic [7:0] v, input int lim);
		for (n = 0; (hi ? COUNT_HI : COUNT_LO) !== v; n++) begin
			if (n == lim)
				timeout();
			@(negedge CLK);
		end
	endtask

	// one-cycle pulse, then the next pulse p cycles after the first
	task automatic period(input logic hi, input int lim, input int p);
		wait_irq(hi, lim);
		cyc(1);
		`CHK(hi ? MATCH_INTERRUPT_HI : MATCH_INTERRUPT_LO, 1'b0)
		wait_irq(hi, lim);
		`CHK(n, p - 1)
		`CHK(hi ? COUNT_HI : COUNT_LO, 8'h00)
	endtask

	// e slow-clock periods of 8 cycles each, counting upper match pulses in k
	task automatic fs_edges(input int e);
		for (int c = 0; c < e * 8; c++) begin
			LOW_FREQ_CLK = (c % 8) < 4;
			@(negedge CLK);
			if (MATCH_INTERRUPT_HI === 1'b1)
				k++;
		end
	endtask

	initial begin
		// a falling edge on reset lets the flops leave their unknown start
		cyc(1);
		ARST_N = 1'b0;
		cyc(4);
		`CHK({MATCH_INTERRUPT_LO, MATCH_INTERRUPT_HI, COUNT_LO, COUNT_HI}, 18'h00000)
		ARST_N = 1'b1;
		foreach (cmps[i]) begin
			TIMER_COMPARE_REG_LO = cmps[i];
			cfg(16'h4300);
			period(1'b0, 2100, int'(cmps[i]) * 8);
			stop();
		end
		TIMER_COMPARE_REG_LO = 8'h06;
		cfg(16'h4300);
		wait_cnt(1'b0, 8'h05, 100);
		stop();
		`CHK(COUNT_LO, 8'h00)
		k = 0;
		repeat (40) begin
			@(negedge CLK);
			if (MATCH_INTERRUPT_LO === 1'b1)
				k++;
		end
		`CHK(k, 0)
		TIMER_COMPARE_REG_LO = 8'hc8;
		cfg(16'h4300);
		wait_cnt(1'b0, 8'h04, 100);
		TIMER_COMPARE_REG_LO = 8'h05;
		wait_irq(1'b0, 12);
		`CHK(COUNT_LO, 8'h00)
		stop();
		foreach (rows[i]) begin
			cfg(rows[i]);
			cyc(3);
			`CHK(SOURCE_SELECT_ERROR, rows[i][0])
			stop();
		end
		LOW_SPEED_MODE = 1'b0;
		TIMER_COMPARE_REG_HI = 8'h01;
		TIMER_COMPARE_REG_LO = 8'h02;
		cfg(16'h1bcc);
		wait_cnt(1'b1, 8'h01, 2200);
		`CHK(COUNT_LO, 8'h00)
		period(1'b1, 2200, 258 * 8);
		stop();
		TIMER_COMPARE_REG_HI = 8'h02;
		for (k = 0; k < 3; k++) begin
			cfg({8'h00, 1'b1, k[2:0], 3'h3, 1'b0});
			period(1'b1, 100, 16);
			stop();
		end
		TIMER_COMPARE_REG_HI = 8'h03;
		cfg(16'h008e);
		repeat (2) begin
			EVENT_PIN = 1'b0;
			cyc(6);
			EVENT_PIN = 1'b1;
			cyc(6);
		end
		`CHK(COUNT_HI, 8'h02)
		EVENT_PIN = 1'b0;
		wait_irq(1'b1, 10);
		EVENT_PIN = 1'b1;
		stop();
		TIMER_COMPARE_REG_HI = 8'h01;
		cfg(16'h0080);
		period(1'b1, 2100, 2048);
		stop();
		DIVIDER_TAP_SELECT = 1'b1;
		cfg(16'h0080);
		k = 0;
		for (n = 0; k == 0 && n < 16; n++)
			fs_edges(1);
		if (k == 0)
			timeout();
		k = 0;
		fs_edges(7);
		`CHK(k, 0)
		fs_edges(1);
		`CHK(k, 1)
		stop();
		summarize();
	end
endmodule
